/* File: core/chip_sync_mode_ctrl.sv */
// Sync mode and path mode registers with the logic they steer.
module chip_sync_mode_ctrl #(
	parameter int DIV_RATIO = sync_mode_pkg::DIV_RATIO_DEF,
	parameter int SAMPLE_W = sync_mode_pkg::SAMPLE_W_DEF
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [sync_mode_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [sync_mode_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [sync_mode_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic sysref_i,
	output logic div_reset_o,
	output logic [7:0] div_phase_o,
	output logic link_down_o,
	output logic monitor_reset_o,
	input wire logic sample_valid_i,
	input wire logic [SAMPLE_W-1:0] sample_i_i,
	input wire logic [SAMPLE_W-1:0] sample_q_i,
	output logic word_valid_o,
	output logic [SAMPLE_W-1:0] word_i_o,
	output logic [SAMPLE_W-1:0] word_q_o,
	output logic word_q_valid_o,
	output logic word_sysref_mark_o,
	output logic full_bw_o,
	output logic [3:0] ddc_enable_o,
	output logic [sync_mode_pkg::DECIM_W-1:0] decim_ratio_o
);
	localparam logic [7:0] DIV_LAST = 8'(DIV_RATIO - 1);

	logic sync_mode_ff;
	logic q_ignore_ff;
	logic [1:0] path_rsvd_ff;
	logic [3:0] app_mode_ff;
	logic [3:0] decim_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic [7:0] div_cnt_ff;
	logic div_reset_ff;
	logic link_down_ff;
	logic monitor_reset_ff;
	logic mark_pending_ff;
	logic word_valid_ff;
	logic [SAMPLE_W-1:0] word_i_ff;
	logic [SAMPLE_W-1:0] word_q_ff;
	logic word_q_valid_ff;
	logic word_mark_ff;
	logic [3:0] ddc_en_ff;
	logic full_bw_ff;
	logic sync_event;
	logic ts_event;
	logic [7:0] nxt_div_cnt;
	logic [7:0] nxt_rdata;

	sysref_evt_if evt_if ();

	sysref_capture u_capture (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sysref_i(sysref_i),
		.evt(evt_if.src)
	);

	// Decode of the path field into DDC enables; undefined codes fall back to full bandwidth
	function automatic logic [3:0] ddc_decode(input logic [3:0] mode);
		logic [3:0] en;
		en = 4'h0;
		unique case (mode)
			sync_mode_pkg::APP_ONE_DDC: en = 4'h1;
			sync_mode_pkg::APP_TWO_DDC: en = 4'h3;
			sync_mode_pkg::APP_FOUR_DDC: en = 4'hF;
			default: en = 4'h0;
		endcase
		return en;
	endfunction

	// ******************************
	// Register writes
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync_mode_ff <= sync_mode_pkg::SYNC_MODE_RST;
			q_ignore_ff <= sync_mode_pkg::Q_IGNORE_RST;
			path_rsvd_ff <= sync_mode_pkg::PATH_RSVD_RST;
			app_mode_ff <= sync_mode_pkg::APP_MODE_RST;
			decim_ff <= sync_mode_pkg::DECIM_RST;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				sync_mode_pkg::SYNC_MODE_OFS: begin
					// Bits 7:1 are read-only and ignored
					sync_mode_ff <= reg_wdata_i[sync_mode_pkg::SYNC_MODE_BIT];
				end
				sync_mode_pkg::PATH_MODE_OFS: begin
					path_rsvd_ff <= reg_wdata_i[sync_mode_pkg::PATH_RSVD_LSB +:
						sync_mode_pkg::PATH_RSVD_W];
					q_ignore_ff <= reg_wdata_i[sync_mode_pkg::Q_IGNORE_BIT];
					app_mode_ff <= reg_wdata_i[sync_mode_pkg::APP_MODE_LSB +:
						sync_mode_pkg::APP_MODE_W];
				end
				sync_mode_pkg::DECIM_OFS: begin
					decim_ff <= reg_wdata_i[sync_mode_pkg::DECIM_LSB +: sync_mode_pkg::DECIM_W];
				end
				default: begin
				end
			endcase
		end
	end

	// ******************************
	// Register reads
	// ******************************
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_addr_i)
			sync_mode_pkg::SYNC_MODE_OFS: nxt_rdata[sync_mode_pkg::SYNC_MODE_BIT] = sync_mode_ff;
			sync_mode_pkg::PATH_MODE_OFS: begin
				nxt_rdata[sync_mode_pkg::PATH_RSVD_LSB +: sync_mode_pkg::PATH_RSVD_W] = path_rsvd_ff;
				nxt_rdata[sync_mode_pkg::Q_IGNORE_BIT] = q_ignore_ff;
				nxt_rdata[sync_mode_pkg::APP_MODE_LSB +: sync_mode_pkg::APP_MODE_W] = app_mode_ff;
			end
			sync_mode_pkg::DECIM_OFS: begin
				nxt_rdata[sync_mode_pkg::DECIM_LSB +: sync_mode_pkg::DECIM_W] = decim_ff;
			end
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'h0;
		end else begin
			rvalid_ff <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// ******************************
	// Event qualification by mode
	// ******************************
	assign sync_event = evt_if.event_pulse & (sync_mode_ff == sync_mode_pkg::SYNC_DIVIDER_RESET);
	assign ts_event = evt_if.event_pulse & (sync_mode_ff == sync_mode_pkg::SYNC_TIMESTAMP);

	// ******************************
	// Internal clock divider
	// ******************************
	always_comb begin
		nxt_div_cnt = (div_cnt_ff == DIV_LAST) ? 8'h00 : div_cnt_ff + 8'h01;
		if (sync_event) begin
			nxt_div_cnt = 8'h00;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt_ff <= 8'h00;
		end else begin
			// Timestamp events do not enter the divider path
			div_cnt_ff <= nxt_div_cnt;
		end
	end

	// ******************************
	// Link and monitor resets
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_reset_ff <= 1'h0;
			link_down_ff <= 1'h0;
			monitor_reset_ff <= 1'h0;
		end else begin
			div_reset_ff <= sync_event;
			// Phase changes only if the divider was not about to wrap anyway
			link_down_ff <= sync_event & (div_cnt_ff != DIV_LAST);
			monitor_reset_ff <= sync_event;
		end
	end

	// ******************************
	// Sample path with timestamp mark
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mark_pending_ff <= 1'h0;
		end else if (ts_event) begin
			// A new event stays pending only when no sample arrives in the same cycle
			mark_pending_ff <= ~sample_valid_i;
		end else if (sample_valid_i) begin
			mark_pending_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			word_valid_ff <= 1'h0;
			word_i_ff <= '0;
			word_q_ff <= '0;
			word_q_valid_ff <= 1'h0;
			word_mark_ff <= 1'h0;
		end else begin
			word_valid_ff <= sample_valid_i;
			if (sample_valid_i) begin
				word_i_ff <= sample_i_i;
				word_q_ff <= q_ignore_ff ? '0 : sample_q_i;
				word_q_valid_ff <= ~q_ignore_ff;
				word_mark_ff <= ts_event | mark_pending_ff;
			end
		end
	end

	// ******************************
	// Path configuration decode
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ddc_en_ff <= 4'h0;
			full_bw_ff <= 1'h1;
		end else begin
			ddc_en_ff <= ddc_decode(app_mode_ff);
			full_bw_ff <= (ddc_decode(app_mode_ff) == 4'h0);
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;
	assign div_reset_o = div_reset_ff;
	assign div_phase_o = div_cnt_ff;
	assign link_down_o = link_down_ff;
	assign monitor_reset_o = monitor_reset_ff;
	assign word_valid_o = word_valid_ff;
	assign word_i_o = word_i_ff;
	assign word_q_o = word_q_ff;
	assign word_q_valid_o = word_q_valid_ff;
	assign word_sysref_mark_o = word_mark_ff;
	assign full_bw_o = full_bw_ff;
	assign ddc_enable_o = ddc_en_ff;
	assign decim_ratio_o = decim_ff;
endmodule

/* File: core/sync_mode_pkg.sv */
// Constants for the chip sync and path mode control registers.
package sync_mode_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] SYNC_MODE_OFS = 15'h01FF;
	localparam logic [ADDR_W-1:0] PATH_MODE_OFS = 15'h0200;
	localparam logic [ADDR_W-1:0] DECIM_OFS = 15'h0201;
	localparam int SYNC_MODE_BIT = 0;
	localparam int Q_IGNORE_BIT = 5;
	localparam int PATH_RSVD_LSB = 6;
	localparam int PATH_RSVD_W = 2;
	localparam int APP_MODE_LSB = 0;
	localparam int APP_MODE_W = 4;
	localparam int DECIM_LSB = 0;
	localparam int DECIM_W = 4;
	localparam logic SYNC_MODE_RST = 1'h0;
	localparam logic Q_IGNORE_RST = 1'h0;
	localparam logic [1:0] PATH_RSVD_RST = 2'h0;
	localparam logic [3:0] APP_MODE_RST = 4'h0;
	localparam logic [3:0] DECIM_RST = 4'h0;
	localparam logic SYNC_DIVIDER_RESET = 1'h0;
	localparam logic SYNC_TIMESTAMP = 1'h1;
	localparam logic [3:0] APP_FULL_BW = 4'h0;
	localparam logic [3:0] APP_ONE_DDC = 4'h1;
	localparam logic [3:0] APP_TWO_DDC = 4'h2;
	localparam logic [3:0] APP_FOUR_DDC = 4'h3;
	localparam int DIV_RATIO_DEF = 4;
	localparam int SAMPLE_W_DEF = 14;
endpackage

/* File: core/sysref_capture.sv */
// Synchronises the timing reference pin and turns its rising edge into a pulse.
module sysref_capture (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sysref_i,
	sysref_evt_if.src evt
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;
	logic pulse_ff;

	// ******************************
	// Two stage synchroniser
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_ff <= 1'h0;
			sync2_ff <= 1'h0;
		end else begin
			sync1_ff <= sysref_i;
			sync2_ff <= sync1_ff;
		end
	end

	// ******************************
	// Rising edge detect
	// ******************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_ff <= 1'h0;
			pulse_ff <= 1'h0;
		end else begin
			prev_ff <= sync2_ff;
			pulse_ff <= sync2_ff & ~prev_ff;
		end
	end

	assign evt.event_pulse = pulse_ff;
	assign evt.level = prev_ff;
endmodule

/* File: core/sysref_evt_if.sv */
// Carries captured timing reference events between capture and control logic.
interface sysref_evt_if;
	logic event_pulse;
	logic level;
	modport src (output event_pulse, output level);
	modport dst (input event_pulse, input level);
endinterface

/* File: dv/chip_sync_mode_ctrl_assertions.sv */
// Checker for the sync mode and path mode register block.
module chip_sync_mode_ctrl_assertions #(
	parameter int DIV_RATIO = 4,
	parameter int SAMPLE_W = 14
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [14:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic div_reset_o,
	input wire logic link_down_o,
	input wire logic monitor_reset_o,
	input wire logic sample_valid_i,
	input wire logic word_valid_o,
	input wire logic word_q_valid_o,
	input wire logic [SAMPLE_W-1:0] word_q_o,
	input wire logic full_bw_o,
	input wire logic [3:0] ddc_enable_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Register bus and steered outputs
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	chk_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	chk_rsvd_sync: assert property (reg_rvalid_o && $past(reg_addr_i) == 15'h01FF |-> reg_rdata_o[7:1] == 7'h00)
		else $error("sync reserved bits set");
	chk_rsvd_path: assert property (reg_rvalid_o && $past(reg_addr_i) == 15'h0200 |-> !reg_rdata_o[4])
		else $error("path reserved bit set");
	chk_unmapped_read: assert property (reg_rvalid_o && $past(reg_addr_i) == 15'h0202 |-> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_mon_div: assert property (div_reset_o == monitor_reset_o)
		else $error("monitor reset apart from divider reset");
	chk_link_div: assert property (link_down_o |-> div_reset_o)
		else $error("link down without divider reset");
	chk_four_ddc: assert property (reg_wr_i && reg_addr_i == 15'h0200 && reg_wdata_i[3:0] == 4'h3 |=> ##1 ddc_enable_o == 4'hF && !full_bw_o)
		else $error("four converter mode not applied");
	chk_full_bw: assert property (full_bw_o |-> ddc_enable_o == 4'h0)
		else $error("converters on in full bandwidth");
	chk_q_drop: assert property (word_valid_o && !word_q_valid_o |-> word_q_o == '0)
		else $error("dropped Q not zero");
	chk_word_lat: assert property (sample_valid_i |=> word_valid_o)
		else $error("word not one cycle after sample");
	chk_div_pulse: assert property (div_reset_o |=> !div_reset_o)
		else $error("divider reset longer than one cycle");
endmodule

bind chip_sync_mode_ctrl chip_sync_mode_ctrl_assertions #(.DIV_RATIO(DIV_RATIO), .SAMPLE_W(SAMPLE_W)) chk (
	.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.div_reset_o(div_reset_o), .link_down_o(link_down_o), .monitor_reset_o(monitor_reset_o),
	.sample_valid_i(sample_valid_i), .word_valid_o(word_valid_o), .word_q_valid_o(word_q_valid_o),
	.word_q_o(word_q_o), .full_bw_o(full_bw_o), .ddc_enable_o(ddc_enable_o));

/* File: dv/chip_sync_mode_ctrl_tb.sv */
// Self-checking testbench for the sync mode and path mode register block.
module chip_sync_mode_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, sysref_i = 0, sample_valid_i = 0;
	logic [14:0] reg_addr_i = '0;
	logic [7:0] reg_wdata_i = '0, reg_rdata_o, div_phase_o, v;
	logic [13:0] sample_i_i = '0, sample_q_i = '0, word_i_o, word_q_o;
	logic reg_rvalid_o, div_reset_o, link_down_o, monitor_reset_o, word_valid_o, word_q_valid_o;
	logic word_sysref_mark_o, full_bw_o;
	logic [3:0] ddc_enable_o, decim_ratio_o;
	logic [31:0] rng = 32'hC15646BD;
	int err_count = 0, tests_run = 0, divs, links, marks, chg;
	chip_sync_mode_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .sysref_i(sysref_i), .div_reset_o(div_reset_o),
		.div_phase_o(div_phase_o), .link_down_o(link_down_o), .monitor_reset_o(monitor_reset_o),
		.sample_valid_i(sample_valid_i), .sample_i_i(sample_i_i), .sample_q_i(sample_q_i),
		.word_valid_o(word_valid_o), .word_i_o(word_i_o), .word_q_o(word_q_o),
		.word_q_valid_o(word_q_valid_o), .word_sysref_mark_o(word_sysref_mark_o),
		.full_bw_o(full_bw_o), .ddc_enable_o(ddc_enable_o), .decim_ratio_o(decim_ratio_o));
	always #25 clk_i = ~clk_i;
	// ****
	// Helpers
	// ****
	function logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function logic [3:0] ddc_exp(input logic [3:0] c);
		case (c)
			4'h1: return 4'h1;
			4'h2: return 4'h3;
			4'h3: return 4'hF;
			default: return 4'h0;
		endcase
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wr(input logic [14:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1;
		@(negedge clk_i);
		reg_wr_i = 0;
		@(negedge clk_i);
	endtask
	task rd(input logic [14:0] a, input logic [7:0] exp);
		reg_addr_i = a;
		reg_rd_i = 1;
		@(negedge clk_i);
		reg_rd_i = 0;
		check({reg_rvalid_o, reg_rdata_o}, {1'b1, exp});
		// Let an edge pass so the next read raises its strobe in a later step
		@(negedge clk_i);
	endtask
	task samp(input logic drop);
		sample_i_i = 14'(xs());
		sample_q_i = 14'(xs());
		sample_valid_i = 1;
		@(negedge clk_i);
		check({word_valid_o, word_i_o}, {1'b1, sample_i_i});
		check({word_q_valid_o, word_q_o}, drop ? 15'h0000 : {1'b1, sample_q_i});
	endtask
	task results();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (16) @(negedge clk_i);
		reset_i = 0;
		@(negedge clk_i);
		check({full_bw_o, ddc_enable_o}, 5'h10);
		rd(15'h01FF, 8'h00);
		rd(15'h0200, 8'h00);
		rd(15'h0201, 8'h00);
		wr(15'h01FF, 8'hFE);
		rd(15'h01FF, 8'h00);
		wr(15'h0202, 8'h5A);
		rd(15'h0202, 8'h00);
		wr(15'h0201, 8'hA5);
		rd(15'h0201, 8'h05);
		check(decim_ratio_o, 4'h5);
		for (int c = 0; c < 6; c++) begin
			// Odd codes always drop Q so the discard path is surely reached
			v = 8'(xs() & 32'hD0 | 32'h10 | c | (c % 2) * 32'h20);
			wr(15'h0200, v);
			check({full_bw_o, ddc_enable_o}, {ddc_exp(v[3:0]) == 4'h0, ddc_exp(v[3:0])});
			rd(15'h0200, v & 8'hEF);
			repeat (3) samp(v[5]);
			sample_valid_i = 0;
		end
		// Bit 0 of m picks the mode, bits 2:1 the divider phase at which the pin rises
		for (int m = 0; m < 8; m++) begin
			wr(15'h01FF, {7'(xs()), m[0]});
			divs = 0;
			links = 0;
			marks = 0;
			chg = 0;
			for (int k = 0; k < 8 && div_phase_o != 8'(m / 2); k++)
				@(negedge clk_i);
			check(div_phase_o, m / 2);
			sysref_i = 1;
			for (int n = 0; n < 14; n++) begin
				v = div_phase_o;
				sample_i_i = 14'(xs());
				// Without bit 2 the event cycle has no sample, so the mark must wait
				sample_valid_i = (n != 3) | m[2];
				@(negedge clk_i);
				if (n == 3) begin
					sysref_i = 0;
					check(div_phase_o, m[0] ? m / 2 : 0);
				end
				divs += (div_reset_o === 1) + (monitor_reset_o === 1);
				links += (link_down_o === 1);
				marks += (word_valid_o === 1 && word_sysref_mark_o === 1);
				// Count steps where the divider left its free-running sequence
				chg += (div_phase_o !== 8'((v + 1) % 4));
			end
			sample_valid_i = 0;
			check(divs, m[0] ? 0 : 2);
			check(marks, m[0]);
			if (m[0]) begin
				check(links, 0);
				check(chg, 0);
			end else
				check(links, chg);
		end
		results();
	end
endmodule
